// ===== include/msm_defs.vh
// Constants for the serial management slave
`ifndef MSM_DEFS_VH
`define MSM_DEFS_VH
`define MSM_OP_READ 2'h2
`define MSM_OP_WRITE 2'h1
`define MSM_START_PAT 2'h1
`define MSM_ADDR_W 5
`define MSM_DATA_W 16
`define MSM_DATA_MSB 4'hf
`define MSM_ADDR_MSB 3'h4
`define MSM_REG_STATUS 5'h01
`define MSM_REG_USER 5'h14
`define MSM_STATUS_VALUE 16'h7849
`define MSM_USER_RESET 16'h0000
`define MSM_CNT_ZERO 4'h0
`define MSM_CNT_ONE 4'h1
`define MSM_SKIP_ZERO 5'h00
`define MSM_SKIP_LAST 5'h16
`define MSM_MDC_MAX_MHZ 25
`endif

// ===== logic/msm_sync.v
// Two-flop synchroniser for an input from outside the clock domain
`timescale 1ns/1ns
module msm_sync (
  input wire clk_sys_i,
  input wire reset_i,
  input wire d_i,
  output reg q_o
);
  reg meta;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // msm_sync

// ===== logic/msm_mgmt_slave.v
// Serial management slave: frame decoder, register 20 and status readback
//
// How it works
// - Input is ignored during turnaround and data of a read frame.
// - Tristate control high except while answering a read; output carries read bits.
// - Fields arrive in fixed order; each frame completes uninterrupted.
// - Frames without preamble are accepted; status bit 6 reads one.
// - Frame begins with start pattern 01 after any preamble ones.
// - Opcode 10 reads, 01 writes.
// - PHY address is five bits, sent most significant first.
// - PHY address matched against the port address select input.
// - Register address is five bits, sent most significant first.
// - Read turnaround: first bit undriven, second bit driven zero.
// - Data is 16 bits, bit 15 first.
// - Line undriven between frames.
// - Register 20 is writable and shown continuously on an output bus.
`timescale 1ns/1ns
`include "msm_defs.vh"
module msm_mgmt_slave (
  input wire clk_sys_i,
  input wire reset_i,
  input wire mgmt_clk_i,
  input wire mgmt_data_i,
  input wire [4:0] port_address_select_i,
  output reg mgmt_data_o,
  output reg mgmt_serial_tristate_o,
  output reg [15:0] user_register_out_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_OP = 3'h2;
  localparam ST_PHY_ADDRESS_FIELD = 3'h3;
  localparam ST_REGISTER_ADDRESS_FIELD = 3'h4;
  localparam ST_TA = 3'h5;
  localparam ST_DATA = 3'h6;
  localparam ST_SKIP = 3'h7;

  wire mdc_s;
  wire mdi_s;
  reg mdc_d;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [1:0] op;
  reg [4:0] phy_address_field;
  reg [4:0] register_address_field;
  reg [15:0] shift;
  reg [15:0] rd_word;
  reg [4:0] skip_cnt;
  wire [4:0] pa_s;
  reg next_tristate;
  reg next_data;

  // System clock must run well above twice the management clock
  msm_sync u_sync_mdc (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .d_i(mgmt_clk_i),
    .q_o(mdc_s)
  );
  msm_sync u_sync_mdi (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .d_i(mgmt_data_i),
    .q_o(mdi_s)
  );

  // Address strap is a pin; static, so skew between its bits is harmless
  genvar gi;
  generate
    for (gi = 0; gi < `MSM_ADDR_W; gi = gi + 1) begin : g_sync_pa
      msm_sync u_sync_pa (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i(port_address_select_i[gi]),
        .q_o(pa_s[gi])
      );
    end
  endgenerate

  wire rise = mdc_s & ~mdc_d;
  wire fall = ~mdc_s & mdc_d;
  wire is_read = (op == `MSM_OP_READ);
  wire addr_hit = ({phy_address_field[3:0], mdi_s} == pa_s);

  // Read data mux; status bit 6 reports preamble suppression
  always @* begin
    case (register_address_field)
      `MSM_REG_STATUS: rd_word = `MSM_STATUS_VALUE;
      `MSM_REG_USER: rd_word = user_register_out_o;
      default: rd_word = 16'h0000;
    endcase
  end

  // Line value taken at the next falling edge
  always @* begin
    next_tristate = 1'b1;
    next_data = 1'b1;
    if (state == ST_TA && is_read && cnt == `MSM_CNT_ONE) begin
      next_tristate = 1'b0;
      next_data = 1'b0;
    end else if (state == ST_DATA && is_read) begin
      next_tristate = 1'b0;
      next_data = shift[cnt];
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      // Same level as the synchroniser reset: no false rising edge
      mdc_d <= 1'b1;
      state <= ST_IDLE;
      cnt <= `MSM_CNT_ZERO;
      skip_cnt <= `MSM_SKIP_ZERO;
      op <= 2'h0;
      phy_address_field <= 5'h00;
      register_address_field <= 5'h00;
      shift <= 16'h0000;
      mgmt_data_o <= 1'b1;
      mgmt_serial_tristate_o <= 1'b1;
      user_register_out_o <= `MSM_USER_RESET;
    end else begin
      mdc_d <= mdc_s;
      if (rise) begin
        case (state)
          ST_IDLE: begin
            // Preamble ones optional; a zero begins the start pattern
            if (!mdi_s) begin
              state <= ST_START;
            end
          end
          ST_START: begin
            if (mdi_s) begin
              state <= ST_OP;
              cnt <= `MSM_CNT_ZERO;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_OP: begin
            op <= {op[0], mdi_s};
            if (cnt == `MSM_CNT_ONE) begin
              cnt <= `MSM_CNT_ZERO;
              state <= ST_PHY_ADDRESS_FIELD;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ST_PHY_ADDRESS_FIELD: begin
            phy_address_field <= {phy_address_field[3:0], mdi_s};
            if (cnt == {1'b0, `MSM_ADDR_MSB}) begin
              cnt <= `MSM_CNT_ZERO;
              if (addr_hit && (op == `MSM_OP_READ || op == `MSM_OP_WRITE)) begin
                state <= ST_REGISTER_ADDRESS_FIELD;
              end else begin
                state <= ST_SKIP;
                skip_cnt <= `MSM_SKIP_ZERO;
              end
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ST_REGISTER_ADDRESS_FIELD: begin
            register_address_field <= {register_address_field[3:0], mdi_s};
            if (cnt == {1'b0, `MSM_ADDR_MSB}) begin
              cnt <= `MSM_CNT_ZERO;
              state <= ST_TA;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ST_TA: begin
            // Read turnaround bits are ours; input not looked at
            if (cnt == `MSM_CNT_ONE) begin
              cnt <= `MSM_DATA_MSB;
              state <= ST_DATA;
              shift <= rd_word;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ST_DATA: begin
            if (!is_read) begin
              shift <= {shift[14:0], mdi_s};
            end
            if (cnt == `MSM_CNT_ZERO) begin
              state <= ST_IDLE;
              if (!is_read && register_address_field == `MSM_REG_USER) begin
                user_register_out_o <= {shift[14:0], mdi_s};
              end
            end else begin
              cnt <= cnt - 4'h1;
            end
          end
          ST_SKIP: begin
            // Foreign or unknown frame: wait out 5+2+16 bit times with line released
            if (skip_cnt == `MSM_SKIP_LAST) begin
              state <= ST_IDLE;
              skip_cnt <= `MSM_SKIP_ZERO;
            end else begin
              skip_cnt <= skip_cnt + 5'h01;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      // Drive changes on the falling edge so it is stable at the rising edge
      if (fall) begin
        mgmt_serial_tristate_o <= next_tristate;
        mgmt_data_o <= next_data;
      end
    end
  end
endmodule // msm_mgmt_slave

// ===== verif/msm_mgmt_slave_checker.sv
// Port assertions for the serial management slave
`timescale 1ns/1ns
module msm_mgmt_slave_checker (
  input wire clk_sys_i,
  input wire reset_i,
  input wire mgmt_clk_i,
  input wire mgmt_data_i,
  input wire [4:0] port_address_select_i,
  input wire mgmt_data_o,
  input wire mgmt_serial_tristate_o,
  input wire [15:0] user_register_out_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  reg [8:0] low_cnt;
  // Cycles spent driving the line
  always @(posedge clk_sys_i) low_cnt <= mgmt_serial_tristate_o ? 9'h0 : low_cnt + 9'h1;
  chk_reset_state: assert property ($past(reset_i) |-> mgmt_serial_tristate_o && mgmt_data_o && !user_register_out_o)
    else $error("bad reset state");
  chk_idle_high: assert property (mgmt_serial_tristate_o |-> mgmt_data_o)
    else $error("idle output low");
  chk_ta_zero: assert property ($fell(mgmt_serial_tristate_o) |-> !mgmt_data_o)
    else $error("turnaround not zero");
  chk_out_quiet: assert property (!$stable(mgmt_data_o) |-> !mgmt_serial_tristate_o || !$past(mgmt_serial_tristate_o))
    else $error("output moved while released");
  chk_bit_hold: assert property (!$stable(mgmt_data_o) && !mgmt_serial_tristate_o |=> $stable(mgmt_data_o) [*6])
    else $error("bit too short");
  chk_drive_max: assert property (low_cnt <= 9'h8c)
    else $error("driving too long");
  chk_drive_min: assert property ($rose(mgmt_serial_tristate_o) |-> $past(low_cnt) >= 9'h84)
    else $error("driving too short");
  chk_user_write: assert property (!$stable(user_register_out_o) |-> mgmt_serial_tristate_o)
    else $error("user register moved in read");
endmodule // msm_mgmt_slave_checker

// ===== verif/msm_station_model.sv
// Station side: drives the management clock and data line
`timescale 1ns/1ns
module msm_station_model (
  input wire logic tri_i,
  input wire logic dout_i,
  output logic mdc_o,
  output wire logic mdio_o
);
  logic en = 0;
  logic d = 1;
  initial mdc_o = 0;
  // Wire level: station, device, else pull-up
  assign mdio_o = en ? d : (tri_i ? 1'b1 : dout_i);
  task automatic bit_t(input logic b, input logic drv, output logic s);
    en = drv;
    d = b;
    #80 mdc_o = 1;
    s = mdio_o;
    #80 mdc_o = 0;
  endtask
  task automatic frame(input int npre, input logic [1:0] op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'b01, op, pa, ra, 2'b10, wd};
    #3;
    repeat (npre) bit_t(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_t(f[i], !(op == 2'b10 && i < 18), s);
      if (i < 16) rd[i] = s;
    end
    en = 0;
  endtask
endmodule // msm_station_model

// ===== verif/test_msm_mgmt_slave.sv
// Testbench for the serial management slave
`timescale 1ns/1ns
module test_msm_mgmt_slave;
  reg clk_sys_i = 0;
  reg reset_i = 1;
  reg [4:0] pa = 5'h0a;
  wire mdc, mdio, dout, tri_en;
  wire [15:0] user_out;
  logic [15:0] rd;
  integer n_errors = 0;
  integer n_checks = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  msm_mgmt_slave i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mgmt_clk_i(mdc), .mgmt_data_i(mdio),
    .port_address_select_i(pa), .mgmt_data_o(dout), .mgmt_serial_tristate_o(tri_en), .user_register_out_o(user_out));
  msm_station_model i_sta (.tri_i(tri_en), .dout_i(dout), .mdc_o(mdc), .mdio_o(mdio));
  task chk(input [15:0] seen, input [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_write;
    i_sta.frame(0, 2'h1, 5'h0a, 5'h14, 16'ha5c3, rd);
    repeat (4) @(posedge clk_sys_i);
    chk(user_out, 16'ha5c3);
  endtask
  task t_read;
    i_sta.frame(32, 2'h2, 5'h0a, 5'h01, 16'h0, rd);
    chk(rd, 16'h7849);
    i_sta.frame(0, 2'h2, 5'h0a, 5'h14, 16'h0, rd);
    chk(rd, 16'ha5c3);
  endtask
  task t_foreign;
    i_sta.frame(1, 2'h1, 5'h1a, 5'h14, 16'h1234, rd);
    i_sta.frame(0, 2'h0, 5'h0a, 5'h14, 16'h1234, rd);
    repeat (4) @(posedge clk_sys_i);
    chk(user_out, 16'ha5c3);
    i_sta.frame(0, 2'h2, 5'h1a, 5'h01, 16'h0, rd);
    chk(rd, 16'hffff);
  endtask
  task t_strap;
    @(posedge clk_sys_i);
    pa <= 5'h1a;
    repeat (4) @(posedge clk_sys_i);
    i_sta.frame(2, 2'h1, 5'h1a, 5'h14, 16'h5a3c, rd);
    repeat (4) @(posedge clk_sys_i);
    chk(user_out, 16'h5a3c);
    i_sta.frame(0, 2'h2, 5'h0a, 5'h14, 16'h0, rd);
    chk(rd, 16'hffff);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk({14'h0, tri_en, dout}, 16'h3);
    t_write();
    t_read();
    t_foreign();
    t_strap();
    wrap_up();
  end
  initial begin
    #200000;
    n_errors = n_errors + 1;
    wrap_up();
  end
endmodule // test_msm_mgmt_slave
bind msm_mgmt_slave msm_mgmt_slave_checker i_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mgmt_clk_i(mgmt_clk_i),
  .mgmt_data_i(mgmt_data_i), .port_address_select_i(port_address_select_i), .mgmt_data_o(mgmt_data_o),
  .mgmt_serial_tristate_o(mgmt_serial_tristate_o), .user_register_out_o(user_register_out_o));
